// *** src/prpc_pkg.sv ***
// Purpose: Constants and types for the PLCA role and precedence control register.
// Assumes: Register reached through a decoded register-access port at one address.
// Notes: Bit positions count from the least significant bit of the 16-bit word.
// Behaviour
// - Bit 15 set ends each PLCA cycle per packet; lower IDs win; resets 0.
// - Bit 11 is reserved, resets to 1, and never affects behaviour.
// - Bit 1 set takes the coordinator role solely from bit 0; resets 0.
// - Bit 1 clear makes coordinator only when the local node ID is zero.
// - With override, bit 0 set is coordinator, clear is ordinary node; resets 0.
package prpc_pkg;
    localparam logic [15:0] PRPC_EXT_CTRL_ADDR = 16'h8002;
    localparam logic [3:0] PRPC_MMS = 4'h4;
    localparam int PRPC_PREC_BIT = 15;
    localparam int PRPC_RSVD_BIT = 11;
    localparam int PRPC_OVR_BIT = 1;
    localparam int PRPC_ROLE_BIT = 0;
    localparam logic PRPC_PREC_RST = 1'h0;
    localparam logic PRPC_RSVD_RST = 1'h1;
    localparam logic PRPC_OVR_RST = 1'h0;
    localparam logic PRPC_ROLE_RST = 1'h0;
    localparam logic [7:0] PRPC_COORD_ID = 8'h00;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] mms;
        logic [15:0] addr;
        logic [15:0] wdata;
    } prpc_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [15:0] rdata;
    } prpc_rsp_t;

    typedef struct packed {
        logic strict_priority_enable;
        logic coordinator;
    } prpc_ctrl_t;
endpackage : prpc_pkg

// *** src/prpc_ctrl.sv ***
// Purpose: Extension control register steering Strict_priority_enable and coordinator role.
// Assumes: Requests arrive as single-cycle strobes from the register-access engine.
// Notes: Read data is answered one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module prpc_ctrl (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Register access.
    input wire prpc_pkg::prpc_req_t req_in,
    output var prpc_pkg::prpc_rsp_t rsp_out,
    // PLCA sublayer side.
    input wire logic [7:0] plca_node_id_in,
    output var prpc_pkg::prpc_ctrl_t ctrl_out
);
    import prpc_pkg::*;

    // Stored fields of the extension control word.
    logic prec_reg;
    logic prec_next;
    logic rsvd_reg;
    logic rsvd_next;
    logic ovr_reg;
    logic ovr_next;
    logic role_reg;
    logic role_next;

    // Registered answer towards the register-access engine.
    prpc_rsp_t rsp_reg;
    prpc_rsp_t rsp_next;

    // Registered levels towards the PLCA sublayer.
    prpc_ctrl_t ctrl_reg;
    prpc_ctrl_t ctrl_next;

    // Request decode.
    logic strobe;
    logic sel;
    logic wr_hit;
    logic rd_hit;
    logic [15:0] rd_word;
    logic id_is_coord;

    // A request counts as a hit only when the memory map and the offset both match.
    always_comb begin
        strobe = req_in.rd || req_in.wr;
        sel = (req_in.mms == PRPC_MMS) && (req_in.addr == PRPC_EXT_CTRL_ADDR);
        wr_hit = sel && req_in.wr;
        rd_hit = sel && req_in.rd;
    end

    // Only the four defined bits keep write data; every other bit has no storage.
    always_comb begin
        prec_next = prec_reg;
        rsvd_next = rsvd_reg;
        ovr_next = ovr_reg;
        role_next = role_reg;
        if (wr_hit) begin
            prec_next = req_in.wdata[PRPC_PREC_BIT];
            rsvd_next = req_in.wdata[PRPC_RSVD_BIT];
            ovr_next = req_in.wdata[PRPC_OVR_BIT];
            role_next = req_in.wdata[PRPC_ROLE_BIT];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            prec_reg <= PRPC_PREC_RST;
            rsvd_reg <= PRPC_RSVD_RST;
            ovr_reg <= PRPC_OVR_RST;
            role_reg <= PRPC_ROLE_RST;
        end else begin
            prec_reg <= prec_next;
            rsvd_reg <= rsvd_next;
            ovr_reg <= ovr_next;
            role_reg <= role_next;
        end
    end

    // Read data shows the stored word, so a read that meets a write returns the old value.
    always_comb begin
        rd_word = 16'h0000;
        rd_word[PRPC_PREC_BIT] = prec_reg;
        rd_word[PRPC_RSVD_BIT] = rsvd_reg;
        rd_word[PRPC_OVR_BIT] = ovr_reg;
        rd_word[PRPC_ROLE_BIT] = role_reg;
        rsp_next.valid = strobe;
        rsp_next.hit = sel && strobe;
        rsp_next.rdata = rd_hit ? rd_word : 16'h0000;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    // The reserved bit is left out here on purpose, so it can never steer the sublayer.
    always_comb begin
        id_is_coord = (plca_node_id_in == PRPC_COORD_ID);
        ctrl_next.strict_priority_enable = prec_next;
        if (ovr_next) begin
            ctrl_next.coordinator = role_next;
        end else begin
            ctrl_next.coordinator = id_is_coord;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign rsp_out = rsp_reg;
    assign ctrl_out = ctrl_reg;

    // Stored fields and the levels derived from them.
    a_prec_follows: assert property (@(posedge core_clk_in) disable iff (srst_in)
        ctrl_out.strict_priority_enable == prec_reg)
        else $error("precedence output differs from register");

    a_prec_store: assert property (@(posedge core_clk_in) disable iff (srst_in)
        wr_hit |=> prec_reg == $past(req_in.wdata[PRPC_PREC_BIT]))
        else $error("precedence bit not stored");

    a_prec_hold: assert property (@(posedge core_clk_in) disable iff (srst_in)
        !wr_hit |=> $stable(prec_reg))
        else $error("precedence bit changed without a write");

    a_prec_reset: assert property (@(posedge core_clk_in)
        srst_in |=> !ctrl_out.strict_priority_enable)
        else $error("precedence output not cleared by reset");

    a_rsvd_store: assert property (@(posedge core_clk_in) disable iff (srst_in)
        wr_hit |=> rsvd_reg == $past(req_in.wdata[PRPC_RSVD_BIT]))
        else $error("reserved bit not stored");

    a_rsvd_hold: assert property (@(posedge core_clk_in) disable iff (srst_in)
        !wr_hit |=> $stable(rsvd_reg))
        else $error("reserved bit changed without a write");

    a_rsvd_inert: assert property (@(posedge core_clk_in) disable iff (srst_in)
        wr_hit && !$past(srst_in) && $stable(plca_node_id_in)
        && (req_in.wdata[PRPC_PREC_BIT] == prec_reg)
        && (req_in.wdata[PRPC_OVR_BIT] == ovr_reg)
        && (req_in.wdata[PRPC_ROLE_BIT] == role_reg) |=> $stable(ctrl_out))
        else $error("reserved bit changed behaviour");

    a_ovr_store: assert property (@(posedge core_clk_in) disable iff (srst_in)
        wr_hit |=> ovr_reg == $past(req_in.wdata[PRPC_OVR_BIT]))
        else $error("override bit not stored");

    a_ovr_hold: assert property (@(posedge core_clk_in) disable iff (srst_in)
        !wr_hit |=> $stable(ovr_reg))
        else $error("override bit changed without a write");

    a_ovr_role: assert property (@(posedge core_clk_in) disable iff (srst_in)
        wr_hit && req_in.wdata[PRPC_OVR_BIT]
        |=> ctrl_out.coordinator == $past(req_in.wdata[PRPC_ROLE_BIT]))
        else $error("override role not applied");

    a_id_role: assert property (@(posedge core_clk_in) disable iff (srst_in)
        !ovr_next |=> ctrl_out.coordinator == ($past(plca_node_id_in) == PRPC_COORD_ID))
        else $error("node id role wrong");

    a_role_store: assert property (@(posedge core_clk_in) disable iff (srst_in)
        wr_hit |=> role_reg == $past(req_in.wdata[PRPC_ROLE_BIT]))
        else $error("role bit not stored");

    a_role_hold: assert property (@(posedge core_clk_in) disable iff (srst_in)
        !wr_hit |=> $stable(role_reg))
        else $error("role bit changed without a write");

    a_role_bit: assert property (@(posedge core_clk_in) disable iff (srst_in)
        ovr_reg |-> ctrl_out.coordinator == role_reg)
        else $error("role bit not obeyed");

    a_node_role: assert property (@(posedge core_clk_in) disable iff (srst_in)
        ovr_reg && !role_reg |-> !ctrl_out.coordinator)
        else $error("ordinary node role not obeyed");

    // Register read path and reset values.
    a_unused_zero: assert property (@(posedge core_clk_in) disable iff (srst_in)
        rsp_out.valid
        |-> (rsp_out.rdata[14:12] == 3'h0) && (rsp_out.rdata[10:2] == 9'h000))
        else $error("unused bits read nonzero");

    a_miss_quiet: assert property (@(posedge core_clk_in) disable iff (srst_in)
        !rd_hit |=> rsp_out.rdata == 16'h0000)
        else $error("read data shown without a matching read");

    a_read_back: assert property (@(posedge core_clk_in) disable iff (srst_in)
        rd_hit && !req_in.wr |=> rsp_out.valid && rsp_out.hit
        && rsp_out.rdata[PRPC_PREC_BIT] == prec_reg)
        else $error("read data wrong");

    a_read_rsvd: assert property (@(posedge core_clk_in) disable iff (srst_in)
        rd_hit && !req_in.wr |=> rsp_out.rdata[PRPC_RSVD_BIT] == rsvd_reg)
        else $error("reserved bit read wrong");

    a_read_role: assert property (@(posedge core_clk_in) disable iff (srst_in)
        rd_hit && !req_in.wr |=> rsp_out.rdata[PRPC_OVR_BIT] == ovr_reg
        && rsp_out.rdata[PRPC_ROLE_BIT] == role_reg)
        else $error("role bits read wrong");

    a_reset_vals: assert property (@(posedge core_clk_in)
        srst_in |=> !prec_reg && rsvd_reg && !ovr_reg && !role_reg)
        else $error("reset values wrong");

    // Main scenarios.
    c_prec_on: cover property (@(posedge core_clk_in) disable iff (srst_in)
        $rose(ctrl_out.strict_priority_enable));

    c_ovr_coord: cover property (@(posedge core_clk_in) disable iff (srst_in)
        ovr_reg && role_reg && plca_node_id_in != PRPC_COORD_ID);

    c_id_coord: cover property (@(posedge core_clk_in) disable iff (srst_in)
        !ovr_reg && ctrl_out.coordinator);

    c_rsvd_flip: cover property (@(posedge core_clk_in) disable iff (srst_in)
        wr_hit && (req_in.wdata[PRPC_RSVD_BIT] != rsvd_reg));

    c_miss_write: cover property (@(posedge core_clk_in) disable iff (srst_in)
        req_in.wr && !sel);
endmodule : prpc_ctrl
`default_nettype wire

// *** bench/prpc_host.sv ***
// Purpose: Host model issuing single-word register accesses.
// Assumes: Strobes change at the falling clock edge.
// Notes: Released strobes clear; the other fields carry inverted values, never stale ones.
`timescale 1ns/10ps
`default_nettype none
module prpc_host (
    // Clock.
    input wire logic core_clk_in,
    // Register access.
    output var prpc_pkg::prpc_req_t req_out,
    input wire prpc_pkg::prpc_rsp_t rsp_in
);
    import prpc_pkg::*;
    initial req_out = '0;
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
                        output prpc_rsp_t r);
        @(negedge core_clk_in);
        req_out = {wr, ~wr, PRPC_MMS, a, d};
        @(negedge core_clk_in);
        req_out = {2'b00, ~PRPC_MMS, ~a, ~d};
        r = rsp_in;
    endtask : xfer
endmodule : prpc_host
`default_nettype wire

// *** bench/tb_prpc_ctrl.sv ***
// Purpose: Self-checking bench for the extension control register.
// Assumes: Every node on the modelled segment runs precedence mode.
// Notes: Each result packs response and control outputs into 20 bits.
`timescale 1ns/10ps
`default_nettype none
module tb_prpc_ctrl;
    import prpc_pkg::*;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] id = 8'h00;
    prpc_req_t req;
    prpc_rsp_t rsp;
    prpc_ctrl_t ctrl;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    prpc_ctrl prpc_ctrl_i (.core_clk_in(core_clk_in), .srst_in(srst_in), .req_in(req),
        .rsp_out(rsp), .plca_node_id_in(id), .ctrl_out(ctrl));
    prpc_host prpc_host_i (.core_clk_in(core_clk_in), .req_out(req), .rsp_in(rsp));
    initial forever #4 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                       input logic [19:0] e);
        prpc_rsp_t r;
        prpc_host_i.xfer(w, a, d, r);
        checks++;
        if ({r, ctrl} !== e) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, {r, ctrl}, e);
        end
    endtask : acc
    task automatic t_defaults;
        acc(1'b0, 16'h8002, 16'h0000, {2'b11, 16'h0800, 2'b01});
        $display("done defaults");
    endtask : t_defaults
    task automatic t_all_ones;
        id = 8'h05;
        acc(1'b1, 16'h8002, 16'hFFFF, {2'b11, 16'h0000, 2'b11});
        acc(1'b0, 16'h8002, 16'h0000, {2'b11, 16'h8803, 2'b11});
        $display("done all ones");
    endtask : t_all_ones
    task automatic t_reserved;
        acc(1'b1, 16'h8002, 16'h8003, {2'b11, 16'h0000, 2'b11});
        acc(1'b0, 16'h8002, 16'h0000, {2'b11, 16'h8003, 2'b11});
        $display("done reserved");
    endtask : t_reserved
    task automatic t_override_node;
        id = 8'h00;
        acc(1'b1, 16'h8002, 16'h0002, {2'b11, 16'h0000, 2'b00});
        acc(1'b0, 16'h8002, 16'h0000, {2'b11, 16'h0002, 2'b00});
        $display("done override node");
    endtask : t_override_node
    task automatic t_id_role;
        acc(1'b1, 16'h8002, 16'h0000, {2'b11, 16'h0000, 2'b01});
        id = 8'h01;
        acc(1'b0, 16'h8002, 16'h0000, {2'b11, 16'h0000, 2'b00});
        $display("done id role");
    endtask : t_id_role
    task automatic t_miss;
        acc(1'b1, 16'h8003, 16'hFFFF, {2'b10, 16'h0000, 2'b00});
        acc(1'b0, 16'h8002, 16'h0000, {2'b11, 16'h0000, 2'b00});
        $display("done miss");
    endtask : t_miss
    task automatic t_reset;
        acc(1'b1, 16'h8002, 16'hFFFF, {2'b11, 16'h0000, 2'b11});
        srst_in = 1'b1;
        repeat (2) @(negedge core_clk_in);
        srst_in = 1'b0;
        acc(1'b0, 16'h8002, 16'h0000, {2'b11, 16'h0800, 2'b00});
        $display("done reset");
    endtask : t_reset
    initial begin
        repeat (10) @(negedge core_clk_in);
        srst_in = 1'b0;
        t_defaults();
        t_all_ones();
        t_reserved();
        t_override_node();
        t_id_role();
        t_miss();
        t_reset();
        conclude();
    end
endmodule : tb_prpc_ctrl
`default_nettype wire
